// ===== inc/rotate_file_map.vh
`ifndef ROTATE_FILE_MAP_VH
`define ROTATE_FILE_MAP_VH

// register byte offsets on the bus
`define REG_CTRL        8'h00
`define REG_INSTR       8'h04
`define REG_WORK        8'h08
`define REG_STATUS      8'h0c
`define REG_BANK        8'h10
`define REG_INDEX       8'h14
`define REG_STATE       8'h18

// reset values
`define CTRL_RESET      1'h0
`define INSTR_RESET     16'h0000
`define WORK_RESET      8'h00
`define STATUS_RESET    5'h00
`define BANK_RESET      4'h0
`define INDEX_RESET     12'h000

// status flag positions
`define FLAG_C          0
`define FLAG_Z          2
`define FLAG_N          4

// control and state register fields
`define CTRL_EXT_BIT    0
`define STATE_BUSY_BIT  0
`define STATE_ILL_BIT   1
`define STATE_IDX_BIT   2
`define STATE_ADDR_LSB  16

// opcode patterns, upper bits of the instruction word
`define OP_RRNC_HI      6'h10
`define OP_RRC_HI       6'h0c
`define OP_SET_FILE_ALL_ONES_OP_HI      7'h34

// instruction fields
`define INSTR_D_BIT     9
`define INSTR_A_BIT     8

// data address forming
`define IDX_LIMIT       8'h5f
`define ACCESS_SPLIT    8'h60
`define ACCESS_HIGH     4'hf
`define ALL_ONES        8'hff

// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== src/file_addr_former.v
`timescale 1ns/1ps
`include "rotate_file_map.vh"

module file_addr_former (
  // instruction fields
  input  wire [7:0]  fileAddr,
  input  wire        bankAccess,
  // address sources
  input  wire        extEnable,
  input  wire [3:0]  bankSel,
  input  wire [11:0] indexBase,
  // formed address
  output reg  [11:0] dataAddr,
  output reg         indexed
);

  // bank bit picks banked, indexed or access-bank addressing
  always @* begin
    indexed = 1'b0;
    if (bankAccess) begin
      dataAddr = {bankSel, fileAddr};
    end else if (extEnable && (fileAddr <= `IDX_LIMIT)) begin
      indexed  = 1'b1;
      dataAddr = indexBase + {4'h0, fileAddr};
    end else if (fileAddr < `ACCESS_SPLIT) begin
      dataAddr = {4'h0, fileAddr};
    end else begin
      dataAddr = {`ACCESS_HIGH, fileAddr};
    end
  end

endmodule

// ===== src/rotate_set_alu.v
`timescale 1ns/1ps
`include "rotate_file_map.vh"

module rotate_set_alu (
  // decoded opcode and operand
  input  wire [15:0] instr,
  input  wire [7:0]  src,
  input  wire        carryIn,
  // result and effects
  output reg  [7:0]  result,
  output reg         carryOut,
  output reg         toFile,
  output reg         setsCarry,
  output reg         setsNz,
  output reg         legal
);

  wire destBit = instr[`INSTR_D_BIT];

  // opcode decode and data processing
  always @* begin
    result    = src;
    carryOut  = carryIn;
    toFile    = 1'b0;
    setsCarry = 1'b0;
    setsNz    = 1'b0;
    legal     = 1'b1;
    if (instr[15:10] == `OP_RRNC_HI) begin
      result = {src[0], src[7:1]};
      toFile = destBit;
      setsNz = 1'b1;
    end else if (instr[15:10] == `OP_RRC_HI) begin
      result    = {carryIn, src[7:1]};
      carryOut  = src[0];
      toFile    = destBit;
      setsCarry = 1'b1;
      setsNz    = 1'b1;
    end else if (instr[15:9] == `OP_SET_FILE_ALL_ONES_OP_HI) begin
      result = `ALL_ONES;
      toFile = 1'b1;
    end else begin
      legal = 1'b0;
    end
  end

endmodule

// ===== src/rotate_file_core.v
// Notes on behaviour
// - decode 0100 00da f as no-carry rotate
// - rotate right, bit0 wraps to bit7
// - no-carry rotate updates only N and Z
// - d=0 writes W, d=1 writes file
// - a=0 access bank, a=1 bank register
// - extended, a=0, f<=95: indexed literal offset
// - one word, four phases: decode, read, process, write
// - 0110 100a f writes ones, no flags
// - rotate through carry updates C, N, Z
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "rotate_file_map.vh"

module rotate_file_core (
  // clock, reset, enable
  input  wire        clock,
  input  wire        nrst,
  input  wire        ce,
  // axi4-lite write address
  input  wire        awvalid,
  output reg         awready,
  input  wire [7:0]  awaddr,
  // axi4-lite write data
  input  wire        wvalid,
  output reg         wready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  // axi4-lite write response
  output reg         bvalid,
  input  wire        bready,
  output reg  [1:0]  bresp,
  // axi4-lite read address
  input  wire        arvalid,
  output reg         arready,
  input  wire [7:0]  araddr,
  // axi4-lite read data
  output reg         rvalid,
  input  wire        rready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  // data memory
  output reg  [11:0] memAddr,
  output reg         memRdEn,
  input  wire [7:0]  memRdData,
  output reg         memWrEn,
  output reg  [7:0]  memWrData
);

  // phase codes of the instruction cycle
  localparam PH_IDLE = 3'h0;
  localparam PH_Q1   = 3'h1;
  localparam PH_Q2   = 3'h2;
  localparam PH_Q3   = 3'h3;
  localparam PH_Q4   = 3'h4;

  // software-visible state
  reg        extEnable;
  reg [15:0] instr;
  reg [7:0]  work;
  reg [4:0]  status;
  reg [3:0]  bankSel;
  reg [11:0] indexBase;
  reg        illegal;
  reg        lastIndexed;

  // sequencer state
  reg [2:0]  phase;
  reg [7:0]  operand;
  reg [7:0]  resultQ;
  reg        carryQ;
  reg        toFileQ;
  reg        setsCarryQ;
  reg        setsNzQ;

  // write channel holding
  reg        awHave;
  reg [7:0]  awAddrQ;
  reg        wHave;
  reg [31:0] wDataQ;
  reg [3:0]  wStrbQ;

  wire        busy = (phase != PH_IDLE);
  wire [11:0] formedAddr;
  wire        formedIndexed;
  wire [7:0]  aluResult;
  wire        aluCarry;
  wire        aluToFile;
  wire        aluSetsCarry;
  wire        aluSetsNz;
  wire        aluLegal;

  file_addr_former addrFormer (
    .fileAddr   (instr[7:0]),
    .bankAccess (instr[`INSTR_A_BIT]),
    .extEnable  (extEnable),
    .bankSel    (bankSel),
    .indexBase  (indexBase),
    .dataAddr   (formedAddr),
    .indexed    (formedIndexed)
  );

  rotate_set_alu alu (
    .instr     (instr),
    .src       (operand),
    .carryIn   (status[`FLAG_C]),
    .result    (aluResult),
    .carryOut  (aluCarry),
    .toFile    (aluToFile),
    .setsCarry (aluSetsCarry),
    .setsNz    (aluSetsNz),
    .legal     (aluLegal)
  );

  // byte-lane merge of the held write data
  wire [31:0] laneMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
  wire        doWrite  = awHave && wHave && !bvalid;
  wire        mapped   = (awAddrQ == `REG_CTRL) || (awAddrQ == `REG_INSTR) ||
                         (awAddrQ == `REG_WORK) || (awAddrQ == `REG_STATUS) ||
                         (awAddrQ == `REG_BANK) || (awAddrQ == `REG_INDEX) ||
                         (awAddrQ == `REG_STATE);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] mask;
    input [31:0] val;
    begin
      merge = (old & ~mask) | (val & mask);
    end
  endfunction

  // merged values of each writable register
  wire [31:0] mCtrl   = merge({31'h0, extEnable}, laneMask, wDataQ);
  wire [31:0] mInstr  = merge({16'h0, instr}, laneMask, wDataQ);
  wire [31:0] mWork   = merge({24'h0, work}, laneMask, wDataQ);
  wire [31:0] mStatus = merge({27'h0, status}, laneMask, wDataQ);
  wire [31:0] mBank   = merge({28'h0, bankSel}, laneMask, wDataQ);
  wire [31:0] mIndex  = merge({20'h0, indexBase}, laneMask, wDataQ);

  // write address and data channels, taken in either order
  always @(posedge clock) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      awHave  <= 1'b0;
      wHave   <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ  <= 32'h00000000;
      wStrbQ  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        awHave  <= 1'b1;
        awready <= 1'b0;
        awAddrQ <= {awaddr[7:2], 2'h0};
      end
      if (wvalid && wready) begin
        wHave  <= 1'b1;
        wready <= 1'b0;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        awHave  <= 1'b0;
        wHave   <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
        bvalid  <= 1'b1;
        bresp   <= mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel, answered one cycle after the address is taken
  always @(posedge clock) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= `RESP_OKAY;
        case ({araddr[7:2], 2'h0})
          `REG_CTRL:   rdata <= {31'h0, extEnable};
          `REG_INSTR:  rdata <= {16'h0, instr};
          `REG_WORK:   rdata <= {24'h0, work};
          `REG_STATUS: rdata <= {27'h0, status};
          `REG_BANK:   rdata <= {28'h0, bankSel};
          `REG_INDEX:  rdata <= {20'h0, indexBase};
          `REG_STATE:  rdata <= {4'h0, memAddr, 13'h0, lastIndexed, illegal, busy};
          default: begin
            rdata <= 32'h00000000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // software writes; the core owns W, status and instr while busy
  always @(posedge clock) begin
    if (!nrst) begin
      extEnable <= `CTRL_RESET;
      bankSel   <= `BANK_RESET;
      indexBase <= `INDEX_RESET;
    end else if (ce && doWrite) begin
      if (awAddrQ == `REG_CTRL)
        extEnable <= mCtrl[`CTRL_EXT_BIT];
      if (awAddrQ == `REG_BANK && !busy)
        bankSel <= mBank[3:0];
      if (awAddrQ == `REG_INDEX && !busy)
        indexBase <= mIndex[11:0];
    end
  end

  // four-phase instruction cycle
  always @(posedge clock) begin
    if (!nrst) begin
      phase       <= PH_IDLE;
      instr       <= `INSTR_RESET;
      work        <= `WORK_RESET;
      status      <= `STATUS_RESET;
      operand     <= 8'h00;
      resultQ     <= 8'h00;
      carryQ      <= 1'b0;
      toFileQ     <= 1'b0;
      setsCarryQ  <= 1'b0;
      setsNzQ     <= 1'b0;
      illegal     <= 1'b0;
      lastIndexed <= 1'b0;
      memAddr     <= 12'h000;
      memRdEn     <= 1'b0;
      memWrEn     <= 1'b0;
      memWrData   <= 8'h00;
    end else if (ce) begin
      memWrEn <= 1'b0;
      case (phase)
        PH_IDLE: begin
          // an instruction write starts a cycle; instr, W and status writes while busy are dropped
          if (doWrite && awAddrQ == `REG_INSTR) begin
            instr <= mInstr[15:0];
            phase <= PH_Q1;
          end
          if (doWrite && awAddrQ == `REG_WORK)
            work <= mWork[7:0];
          if (doWrite && awAddrQ == `REG_STATUS)
            status <= mStatus[4:0];
        end
        PH_Q1: begin
          // decode: form the operand address and request the read
          memAddr     <= formedAddr;
          lastIndexed <= formedIndexed;
          memRdEn     <= 1'b1;
          phase       <= PH_Q2;
        end
        PH_Q2: begin
          // read register f
          operand <= memRdData;
          memRdEn <= 1'b0;
          phase   <= PH_Q3;
        end
        PH_Q3: begin
          // process data; an unknown opcode completes as a no-op
          resultQ    <= aluResult;
          carryQ     <= aluCarry;
          toFileQ    <= aluToFile && aluLegal;
          setsCarryQ <= aluSetsCarry;
          setsNzQ    <= aluSetsNz;
          illegal    <= !aluLegal;
          phase      <= PH_Q4;
        end
        PH_Q4: begin
          // write to destination and the affected flags only
          if (toFileQ) begin
            memWrEn   <= 1'b1;
            memWrData <= resultQ;
          end else if (!illegal) begin
            work <= resultQ;
          end
          if (setsNzQ) begin
            status[`FLAG_N] <= resultQ[7];
            status[`FLAG_Z] <= (resultQ == 8'h00);
          end
          if (setsCarryQ)
            status[`FLAG_C] <= carryQ;
          phase <= PH_IDLE;
        end
        default: phase <= PH_IDLE;
      endcase
    end
  end

endmodule

// ===== tb/rotate_file_checker.sv
`timescale 1ns/1ps
// bus handshake and instruction phase checks
module rotate_file_checker (
  // clock and reset
  input logic        clock,
  input logic        nrst,
  input logic        ce,
  // register bus
  input logic        awvalid,
  input logic        awready,
  input logic        wvalid,
  input logic        wready,
  input logic        bvalid,
  input logic        bready,
  input logic [1:0]  bresp,
  input logic        arvalid,
  input logic        arready,
  input logic        rvalid,
  input logic        rready,
  input logic [31:0] rdata,
  // data memory
  input logic [11:0] memAddr,
  input logic        memRdEn,
  input logic        memWrEn
);
  default clocking @(posedge clock); endclocking
  // a frozen cycle stretches every timing below but the reset check, so such attempts are dropped
  default disable iff (!nrst || !$sampled(ce));

  // both write halves taken together, answer two edges on
  sequence s_take;
    awvalid && awready && wvalid && wready;
  endsequence
  // address must not wander between read and write phases
  sequence s_hold;
    !memRdEn && $stable(memAddr) [*3];
  endsequence

  property p_bans;
    s_take |=> !awready && !bvalid ##1 bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write answer timing");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rans;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer timing");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_fetch;
    memRdEn |=> s_hold;
  endproperty
  a_fetch: assert property (p_fetch) else $error("read phase wrong");
  property p_wrpos;
    memWrEn |-> $past(memRdEn, 3);
  endproperty
  a_wrpos: assert property (p_wrpos) else $error("write phase misplaced");
  property p_wpulse;
    memWrEn |=> !memWrEn;
  endproperty
  a_wpulse: assert property (p_wpulse) else $error("write not a pulse");
  property p_reset;
    disable iff (1'b0) !nrst |=> awready && arready && !bvalid && !rvalid && !memWrEn;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule

bind rotate_file_core rotate_file_checker chk (.clock, .nrst, .ce, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .memAddr, .memRdEn, .memWrEn);

// ===== tb/rotate_right_and_set_file_ops_test.sv
`timescale 1ns/1ps
`include "rotate_file_map.vh"
// random instruction runs against a behavioural model
module rotate_right_and_set_file_ops_test;
  logic        clock, nrst, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, f, w, src, res;
  logic [31:0] wdata, rdat;
  logic [3:0]  wstrb, bk;
  logic [1:0]  rsp, op;
  logic [4:0]  st;
  logic [11:0] ix, ad;
  logic [15:0] seed, ins;
  logic        ext, a, d, idx, lateReady;
  logic [7:0]  mem [0:4095];
  integer      errorCnt, nTests, i;
  wire         awready, wready, bvalid, arready, rvalid, memRdEn, memWrEn;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [11:0] memAddr;
  wire  [7:0]  memWrData;

  // memory answers combinationally, as the read phase needs
  rotate_file_core DUT (.clock, .nrst, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .memAddr, .memRdEn, .memRdData(mem[memAddr]), .memWrEn,
    .memWrData);

  // memory takes the write pulse
  always @(posedge clock)
    if (memWrEn) mem[memAddr] <= memWrData;

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task check(input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e) begin
      errorCnt++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task finishTest;
    $display("checks %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // each half released once taken; ready offered at once or, when late, after the answer
  task wr(input logic [7:0] ad8, input logic [31:0] dt);
    @(posedge clock);
    awaddr <= ad8;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !lateReady;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] ad8);
    @(posedge clock);
    araddr <= ad8;
    arvalid <= 1'b1;
    rready <= !lateReady;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rdat = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // start an instruction and poll until it is no longer busy
  task run(input logic [15:0] in);
    wr(`REG_INSTR, {16'h0000, in});
    rdat = 32'h00000001;
    while (rdat[0] !== 1'b0)
      rd(`REG_STATE);
  endtask

  // hang guard, far above the roughly 9k cycles the run needs
  initial begin
    repeat (60000) @(posedge clock);
    errorCnt++;
    finishTest;
  end

  initial begin
    errorCnt = 0;
    nTests = 0;
    seed = 16'h000a;
    lateReady = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    for (i = 0; i < 4096; i++)
      mem[i] = 8'h00;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    rd(`REG_STATUS);
    check(rdat, 32'h00000000);
    rd(8'h40);
    check({rdat[29:0], rsp}, {30'h0, `RESP_SLVERR});
    // write answers: unmapped refused, mapped accepted
    wr(8'h40, 32'h00000000);
    check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(`REG_CTRL, 32'h00000000);
    check({30'h0, rsp}, {30'h0, `RESP_OKAY});
    // neighbouring opcode is not a rotate: no write, illegal flag
    run(16'h4700);
    check(rdat & 32'h00000002, 32'h00000002);
    // every op, both dest and bank bits, index edges 5f and 60
    for (i = 0; i < 240; i++) begin
      seed = lfsr(seed);
      op = 2'(i % 3);
      // every fourth pass the master answers late, so held answers are seen
      lateReady = (i % 4 == 3);
      f = (i % 8 == 0) ? 8'h5f : (i % 8 == 1) ? 8'h60 : seed[7:0];
      {ext, d, a} = seed[10:8];
      seed = lfsr(seed);
      {st, bk, w} = {seed[15:11], seed[11:8], seed[7:0]};
      seed = lfsr(seed);
      {ix, src} = {seed[11:0], seed[15:8]};
      idx = ext && !a && f <= 8'h5f;
      ad = idx ? ix + {4'h0, f} : a ? {bk, f} : f < 8'h60 ? {4'h0, f} : {4'hf, f};
      ins = op == 2'h2 ? {`OP_SET_FILE_ALL_ONES_OP_HI, a, f} : {op ? `OP_RRC_HI : `OP_RRNC_HI, d, a, f};
      res = op == 2'h2 ? 8'hff : {op ? st[0] : src[0], src[7:1]};
      mem[ad] = src;
      wr(`REG_CTRL, {31'h0, ext});
      wr(`REG_BANK, {28'h0, bk});
      wr(`REG_INDEX, {20'h0, ix});
      wr(`REG_WORK, {24'h0, w});
      wr(`REG_STATUS, {27'h0, st});
      run(ins);
      check(rdat & 32'h0fff0006, {4'h0, ad, 13'h0, idx, 2'h0});
      check({24'h0, mem[ad]}, {24'h0, (op == 2'h2 || d) ? res : src});
      rd(`REG_WORK);
      check(rdat, {24'h0, (op != 2'h2 && !d) ? res : w});
      rd(`REG_STATUS);
      if (op == 2'h2) check(rdat, {27'h0, st});
      else check(rdat, {27'h0, res[7], st[3], res == 8'h00, st[1], op ? src[0] : st[0]});
    end
    // clock enable low: a read offered meanwhile is neither taken nor answered
    @(posedge clock);
    ce <= 1'b0;
    araddr <= `REG_WORK;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (3) @(posedge clock);
    check({30'h0, rvalid, arready}, 32'h00000001);
    ce <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    check(rdata, {24'h0, (op != 2'h2 && !d) ? res : w});
    rready <= 1'b0;
    finishTest;
  end
endmodule
